// ### core/hps_line_mem.sv
`timescale 1ns/1ps
module hps_line_mem #(
  parameter int AW = 11,
  parameter int DW = 8
) (
  input  wire logic          core_clk_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] waddr_i,
  input  wire logic [DW-1:0] wdata_i,
  input  wire logic [AW-1:0] raddr_i,
  output logic      [DW-1:0] rdata_o
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge core_clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end
endmodule // hps_line_mem

// ### core/hps_pkg.sv
package hps_pkg;
  // Register addresses
  localparam logic [7:0] ADDR_ENL_HI   = 8'h08;
  localparam logic [7:0] ADDR_SHR_HI   = 8'h09;
  localparam logic [7:0] ADDR_OFF_HI   = 8'h0a;
  localparam logic [7:0] ADDR_CTRL     = 8'h0b;
  // Reset values
  localparam logic [7:0] RST_ENL_HI    = 8'hff;
  localparam logic [7:0] RST_SHR_HI    = 8'h40;
  localparam logic [7:0] RST_OFF_HI    = 8'h00;
  localparam logic [7:0] RST_CTRL      = 8'hc0;
  // Control register fields
  localparam int         CTRL_ENL_LSB  = 6;
  localparam int         CTRL_SHR_LSB  = 4;
  localparam int         CTRL_OFF_LSB  = 2;
  localparam int         CTRL_SHR_EN   = 1;
  localparam int         CTRL_ENL_EN   = 0;
  // Factor coding
  localparam int         FACT_W        = 10;
  localparam int         FRAC_W        = 10;
  localparam logic [FACT_W-1:0] FACT_MIN = 10'h100;
  localparam logic [11:0] UNITY_STEP   = 12'h400;
  localparam int         SHR_SHIFT     = 2;
  // Nominal luma samples per active line
  localparam logic [10:0] PPL_NORMAL   = 11'h2d0;
  localparam logic [10:0] PPL_SQ_SMALL = 11'h280;
  localparam logic [10:0] PPL_SQ_LARGE = 11'h300;
  localparam logic [10:0] ONE_PIX      = 11'h001;

  typedef enum logic [1:0] {
    HPS_UNITY,
    HPS_ENLARGE,
    HPS_SHRINK,
    HPS_PANORAMA
  } hps_mode_type;
endpackage

// ### core/hps_scaler.sv
`timescale 1ns/1ps
// What this block does
// - Both enables set selects panorama, using both factors and border width.
// - Panorama applies the enlarge factor at both line edges.
// - Panorama applies the shrink factor in the line centre.
// - Border width sets left ramp to shrink and mirrored right ramp back.
// - Pixels per line are 720 normal, 640 or 768 square pixel.
// - Shrink enable: 0 disables, 1 enables; resets disabled.
// - Enlarge enable: 0 disables, 1 enables; resets disabled.
// - Shrink factor low two bits sit in the control register.
// - Border width/offset low two bits sit in the control register.
// - Enlarge factor 256..1023; 3FFh unity, 200h double, 100h four times.
// - Shrink factor 256..1023; 100h unity, 3FFh quarter width.
// - Enlarge only: offset picks first input pixel used; zero is leftmost.
module hps_scaler (
  input  wire logic       core_clk_i,
  input  wire logic       rst_i,
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  output logic      [7:0] reg_rdata_o,
  input  wire logic       sq_pixel_i,
  input  wire logic       sq_large_i,
  input  wire logic       in_valid_i,
  input  wire logic       in_sol_i,
  input  wire logic [7:0] in_data_i,
  output logic            out_valid_o,
  output logic            out_sol_o,
  output logic      [7:0] out_data_o
);
  import hps_pkg::*;

  localparam int AW = 11;
  localparam int PW = AW + FRAC_W;

  logic [7:0]        enl_hi_r, enl_hi_nxt, shr_hi_r, shr_hi_nxt;
  logic [7:0]        off_hi_r, off_hi_nxt, ctrl_r, ctrl_nxt;
  logic [7:0]        rdata_r, rdata_nxt;
  logic [FACT_W-1:0] zin_r, zin_nxt, zout_r, zout_nxt, zt_r, zt_nxt;
  hps_mode_type      mode_r, mode_nxt;
  logic [10:0]       n_r, n_nxt, out_cnt_r, out_cnt_nxt;
  logic [10:0]       wr_cnt_r, wr_cnt_nxt;
  logic              bank_r, bank_nxt, rd_act_r, rd_act_nxt;
  logic [PW-1:0]     phase_r, phase_nxt;
  logic              oval_r, oval_nxt, osol_r, osol_nxt;
  logic              line_start;
  logic [10:0]       pos, pos_m;
  logic [11:0]       zout4, step;
  logic [22:0]       ramp;

  assign line_start = in_valid_i && in_sol_i;
  assign pos        = phase_r[PW-1:FRAC_W];
  assign zout4      = {zout_r, 2'b00};

  // Step in 1/1024 input pixel per output pixel
  always_comb begin
    pos_m = n_r - ONE_PIX - pos;
    ramp  = '0;
    case (mode_r)
      HPS_ENLARGE:  step = {2'b00, zin_r};
      HPS_SHRINK:   step = zout4;
      HPS_PANORAMA: begin
        if ({1'b0, zt_r} > pos) begin
          // Linear ramp; left edge equals enlarge factor
          ramp = 23'(zout4 - {2'b00, zin_r}) * 23'(pos) / 23'(zt_r);
          step = 12'({2'b00, zin_r} + ramp[11:0]);
        end else if ({1'b0, zt_r} > pos_m) begin
          ramp = 23'(zout4 - {2'b00, zin_r}) * 23'(pos_m) / 23'(zt_r);
          step = 12'({2'b00, zin_r} + ramp[11:0]);
        end else begin
          step = zout4;
        end
      end
      default:      step = UNITY_STEP;
    endcase
  end

  always_comb begin
    enl_hi_nxt  = enl_hi_r;
    shr_hi_nxt  = shr_hi_r;
    off_hi_nxt  = off_hi_r;
    ctrl_nxt    = ctrl_r;
    rdata_nxt   = rdata_r;
    zin_nxt     = zin_r;
    zout_nxt    = zout_r;
    zt_nxt      = zt_r;
    mode_nxt    = mode_r;
    n_nxt       = n_r;
    bank_nxt    = bank_r;
    wr_cnt_nxt  = wr_cnt_r;
    rd_act_nxt  = rd_act_r;
    phase_nxt   = phase_r;
    out_cnt_nxt = out_cnt_r;
    oval_nxt    = rd_act_r;
    osol_nxt    = rd_act_r && (out_cnt_r == '0);
    if (reg_wr_i) begin
      case (reg_addr_i)
        ADDR_ENL_HI: enl_hi_nxt = reg_wdata_i;
        ADDR_SHR_HI: shr_hi_nxt = reg_wdata_i;
        ADDR_OFF_HI: off_hi_nxt = reg_wdata_i;
        ADDR_CTRL:   ctrl_nxt   = reg_wdata_i;
        default:     ;
      endcase
    end
    if (reg_rd_i) begin
      case (reg_addr_i)
        ADDR_ENL_HI: rdata_nxt = enl_hi_r;
        ADDR_SHR_HI: rdata_nxt = shr_hi_r;
        ADDR_OFF_HI: rdata_nxt = off_hi_r;
        ADDR_CTRL:   rdata_nxt = ctrl_r;
        default:     rdata_nxt = '0;
      endcase
    end
    if (in_valid_i) begin
      wr_cnt_nxt = wr_cnt_r + ONE_PIX;
    end
    if (rd_act_r) begin
      phase_nxt   = PW'(phase_r + {{(PW-12){1'b0}}, step});
      out_cnt_nxt = out_cnt_r + ONE_PIX;
      if (out_cnt_r == n_r - ONE_PIX) begin
        rd_act_nxt = 1'b0;
      end
    end
    // Parameters are sampled only here, so a line never mixes settings
    if (line_start) begin
      bank_nxt   = ~bank_r;
      wr_cnt_nxt = ONE_PIX;
      zin_nxt    = {enl_hi_r, ctrl_r[CTRL_ENL_LSB +: 2]};
      zout_nxt   = {shr_hi_r, ctrl_r[CTRL_SHR_LSB +: 2]};
      zt_nxt     = {off_hi_r, ctrl_r[CTRL_OFF_LSB +: 2]};
      mode_nxt   = hps_mode_type'({ctrl_r[CTRL_SHR_EN],
                                   ctrl_r[CTRL_ENL_EN]});
      n_nxt      = !sq_pixel_i ? PPL_NORMAL :
                   (sq_large_i ? PPL_SQ_LARGE : PPL_SQ_SMALL);
      rd_act_nxt = 1'b1;
      out_cnt_nxt = '0;
      phase_nxt  = '0;
      if (!ctrl_r[CTRL_SHR_EN] && ctrl_r[CTRL_ENL_EN]) begin
        phase_nxt = {1'b0, off_hi_r, ctrl_r[CTRL_OFF_LSB +: 2],
                     {FRAC_W{1'b0}}};
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      enl_hi_r  <= RST_ENL_HI;
      shr_hi_r  <= RST_SHR_HI;
      off_hi_r  <= RST_OFF_HI;
      ctrl_r    <= RST_CTRL;
      rdata_r   <= '0;
      zin_r     <= {RST_ENL_HI, RST_CTRL[CTRL_ENL_LSB +: 2]};
      zout_r    <= {RST_SHR_HI, RST_CTRL[CTRL_SHR_LSB +: 2]};
      zt_r      <= {RST_OFF_HI, RST_CTRL[CTRL_OFF_LSB +: 2]};
      mode_r    <= HPS_UNITY;
      n_r       <= PPL_NORMAL;
      bank_r    <= 1'b0;
      wr_cnt_r  <= '0;
      rd_act_r  <= 1'b0;
      phase_r   <= '0;
      out_cnt_r <= '0;
      oval_r    <= 1'b0;
      osol_r    <= 1'b0;
    end else begin
      enl_hi_r  <= enl_hi_nxt;
      shr_hi_r  <= shr_hi_nxt;
      off_hi_r  <= off_hi_nxt;
      ctrl_r    <= ctrl_nxt;
      rdata_r   <= rdata_nxt;
      zin_r     <= zin_nxt;
      zout_r    <= zout_nxt;
      zt_r      <= zt_nxt;
      mode_r    <= mode_nxt;
      n_r       <= n_nxt;
      bank_r    <= bank_nxt;
      wr_cnt_r  <= wr_cnt_nxt;
      rd_act_r  <= rd_act_nxt;
      phase_r   <= phase_nxt;
      out_cnt_r <= out_cnt_nxt;
      oval_r    <= oval_nxt;
      osol_r    <= osol_nxt;
    end
  end

  // Ping-pong line store: one bank fills while the other is read
  hps_line_mem #(.AW(AW + 1), .DW(8)) u_mem (
    .core_clk_i (core_clk_i),
    .we_i       (in_valid_i),
    .waddr_i    (line_start ? {~bank_r, {AW{1'b0}}} : {bank_r, wr_cnt_r}),
    .wdata_i    (in_data_i),
    .raddr_i    ({~bank_r, pos}),
    .rdata_o    (out_data_o)
  );

  assign reg_rdata_o = rdata_r;
  assign out_valid_o = oval_r;
  assign out_sol_o   = osol_r;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  a_panorama_mode: assert property (line_start && ctrl_r[CTRL_SHR_EN]
    && ctrl_r[CTRL_ENL_EN] |=> mode_r == HPS_PANORAMA)
    else $error("panorama not entered with both enables");
  a_edge_enlarge: assert property (rd_act_r && mode_r == HPS_PANORAMA
    && pos == '0 && zt_r != '0 |-> step == {2'b00, zin_r})
    else $error("left edge step differs from enlarge factor");
  a_centre_shrink: assert property (rd_act_r && mode_r == HPS_PANORAMA
    && {1'b0, zt_r} <= pos && {1'b0, zt_r} <= pos_m |-> step == zout4)
    else $error("centre step differs from shrink factor");
  a_border_ramp: assert property (rd_act_r && mode_r == HPS_PANORAMA
    && zout4 >= {2'b00, zin_r}
    |-> step >= {2'b00, zin_r} && step <= zout4)
    else $error("border step outside factor range");
  a_line_length: assert property (line_start ##1 1'b1
    |-> n_r == PPL_NORMAL || n_r == PPL_SQ_SMALL || n_r == PPL_SQ_LARGE)
    else $error("bad pixels per line");
  a_shrink_enable: assert property (line_start
    |=> (mode_r[1] == $past(ctrl_r[CTRL_SHR_EN])))
    else $error("shrink enable not applied");
  a_enlarge_enable: assert property (line_start
    |=> (mode_r[0] == $past(ctrl_r[CTRL_ENL_EN])))
    else $error("enlarge enable not applied");
  a_shrink_concat: assert property (line_start
    |=> zout_r == $past({shr_hi_r, ctrl_r[CTRL_SHR_LSB +: 2]}))
    else $error("shrink factor assembled wrongly");
  a_offset_concat: assert property (line_start
    |=> zt_r == $past({off_hi_r, ctrl_r[CTRL_OFF_LSB +: 2]}))
    else $error("offset assembled wrongly");
  a_offset_start: assert property (line_start && !ctrl_r[CTRL_SHR_EN]
    && ctrl_r[CTRL_ENL_EN]
    |=> pos == {1'b0, zt_r} && phase_r[FRAC_W-1:0] == '0)
    else $error("enlarge start pixel wrong");
  a_uniform_step: assert property (rd_act_r && mode_r == HPS_UNITY
    ##1 rd_act_r |-> phase_r == $past(phase_r) + PW'(UNITY_STEP))
    else $error("unity line does not advance one pixel");
  a_params_hold: assert property (!line_start
    |=> $stable(zin_r) && $stable(zout_r) && $stable(mode_r))
    else $error("parameters changed inside a line");
  a_line_output: assert property (line_start ##1 !line_start [*2]
    |-> oval_r && osol_r)
    else $error("output line did not start");

  c_panorama: cover property (rd_act_r && mode_r == HPS_PANORAMA);
  c_shrink:   cover property (rd_act_r && mode_r == HPS_SHRINK);
  c_enlarge:  cover property (rd_act_r && mode_r == HPS_ENLARGE);
  c_reg_wr:   cover property (reg_wr_i && reg_addr_i == ADDR_CTRL);
endmodule // hps_scaler

// ### sim/hps_scaler_tb.sv
`timescale 1ns/1ps
module hps_scaler_tb;
  import hps_pkg::*;
  logic       core_clk_i  = 1'b0;
  logic       rst_i       = 1'b1;
  logic [7:0] reg_addr_i  = 8'h00;
  logic [7:0] reg_wdata_i = 8'h00;
  logic       reg_wr_i    = 1'b0;
  logic       reg_rd_i    = 1'b0;
  logic       sq_pixel_i  = 1'b0;
  logic       sq_large_i  = 1'b0;
  logic [7:0] reg_rdata_o, in_data_i, out_data_o;
  logic       in_valid_i, in_sol_i, out_valid_o, out_sol_o;
  logic [9:0] expq [$];
  logic [9:0] e;
  logic [7:0] prev [0:1023];
  int n_fail = 0, checks_done = 0, prev_n = 0, seed = 32'h5595305b;
  int zin, zout, zt, en;
  // Panorama set keeps border*(4*shrink-enlarge) = 720*(4*shrink-1024)
  int t_in [4]  = '{'h3ff, 'h2aa, 'h3ff, 'h200};
  int t_out [4] = '{'h100, 'h100, 'h1c3, 'h140};
  int t_off [4] = '{0, 'h0d5, 0, 'h0f0};

  hps_scaler u_hps_scaler (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .sq_pixel_i(sq_pixel_i), .sq_large_i(sq_large_i),
    .in_valid_i(in_valid_i), .in_sol_i(in_sol_i), .in_data_i(in_data_i),
    .out_valid_o(out_valid_o), .out_sol_o(out_sol_o),
    .out_data_o(out_data_o));
  hps_src_model u_hps_src_model (.core_clk_i(core_clk_i),
    .valid_o(in_valid_i), .sol_o(in_sol_i), .data_o(in_data_i));

  always #10 core_clk_i = ~core_clk_i;

  task automatic fail_line(input logic [8:0] got, input logic [8:0] exp);
    n_fail++;
    $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
  endtask
  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) fail_line({1'b0, got}, {1'b0, exp});
  endtask
  task automatic chk_pix(input logic [8:0] got, input logic [8:0] exp);
    checks_done++;
    if (got !== exp) fail_line(got, exp);
  endtask
  task automatic give_verdict();
    $display("checks=%0d failures=%0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_i    <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_i   <= 1'b0;
    #1 chk_reg(reg_rdata_o, exp);
  endtask
  task automatic set(input int m, input int a, input int b, input int c);
    logic [9:0] x, y, z;
    x = a[9:0];
    y = b[9:0];
    z = c[9:0];
    wr(ADDR_ENL_HI, x[9:2]);
    wr(ADDR_SHR_HI, y[9:2]);
    wr(ADDR_OFF_HI, z[9:2]);
    wr(ADDR_CTRL, {x[1:0], y[1:0], z[1:0], m[1:0]});
    rd(ADDR_CTRL, {x[1:0], y[1:0], z[1:0], m[1:0]});
    en = m; zin = a; zout = b; zt = c;
  endtask

  // Output of this line replays the previous input line
  task automatic line(input int n);
    int ph, st, p, q, r;
    ph = (en == 1) ? zt * 1024 : 0;
    for (int j = 0; j < n; j++) begin
      p = ph >>> 10;
      q = n - 1 - p;
      expq.push_back({j == 0, p >= prev_n, prev[p & 1023]});
      case (en)
        0: st = 1024;
        1: st = zin;
        2: st = 4 * zout;
        default: begin
          if (p < zt) st = zin + (4 * zout - zin) * p / zt;
          else if (q >= 0 && q < zt)
            st = zin + (4 * zout - zin) * q / zt;
          else st = 4 * zout;
        end
      endcase
      ph += st;
    end
    for (int j = 0; j < n; j++) begin
      r = $random(seed);
      u_hps_src_model.pix[j] = r[7:0];
    end
    u_hps_src_model.send_line(n);
    for (int j = 0; j < n; j++) prev[j] = u_hps_src_model.pix[j];
    prev_n = n;
  endtask

  // Sampled mid-cycle, where the registered outputs are settled
  always @(negedge core_clk_i) begin
    if (!rst_i && out_valid_o === 1'b1) begin
      if (expq.size() == 0) fail_line({out_sol_o, out_data_o}, 9'h000);
      else begin
        e = expq.pop_front();
        if (e[8]) chk_pix({out_sol_o, 8'h00}, {e[9], 8'h00});
        else chk_pix({out_sol_o, out_data_o}, {e[9], e[7:0]});
      end
    end
  end

  initial begin
    repeat (30000) @(posedge core_clk_i);
    n_fail++;
    give_verdict();
  end

  initial begin
    en = 0; zin = 'h3ff; zout = 'h100; zt = 0;
    repeat (3) @(posedge core_clk_i);
    rst_i <= 1'b0;
    rd(ADDR_ENL_HI, RST_ENL_HI);
    rd(ADDR_SHR_HI, RST_SHR_HI);
    rd(ADDR_OFF_HI, RST_OFF_HI);
    rd(ADDR_CTRL, RST_CTRL);
    wr(8'h0c, 8'h5a);
    rd(8'h0c, 8'h00);
    line(720);
    for (int m = 0; m < 4; m++) begin
      set(m, t_in[m], t_out[m], t_off[m]);
      line(720);
    end
    sq_pixel_i <= 1'b1;
    line(640);
    sq_large_i <= 1'b1;
    line(768);
    sq_pixel_i <= 1'b0;
    set(3, t_in[3], t_out[3], t_off[3]);
    line(720);
    // Settings written mid-line must wait for the next line start
    fork
      line(720);
      begin
        repeat (200) @(posedge core_clk_i);
        set(0, 'h3ff, 'h100, 0);
      end
    join
    line(720);
    for (int k = 0; k < 800 && expq.size() != 0; k++) @(posedge core_clk_i);
    if (expq.size() != 0) fail_line(9'h000, 9'h000);
    give_verdict();
  end
endmodule // hps_scaler_tb

// ### sim/hps_src_model.sv
`timescale 1ns/1ps
module hps_src_model (
  input  wire logic       core_clk_i,
  output logic            valid_o,
  output logic            sol_o,
  output logic      [7:0] data_o
);
  logic [7:0] pix [0:1023];

  initial begin
    valid_o = 1'b0;
    sol_o   = 1'b0;
    data_o  = 8'h00;
  end

  // One active line back to back; the idle tail keeps lines N+5 apart
  task automatic send_line(input int n);
    for (int j = 0; j < n; j++) begin
      @(posedge core_clk_i);
      valid_o <= 1'b1;
      sol_o   <= (j == 0);
      data_o  <= pix[j];
    end
    @(posedge core_clk_i);
    valid_o <= 1'b0;
    sol_o   <= 1'b0;
    data_o  <= ~data_o;  // Idle bus must not look like a valid sample
    repeat (4) @(posedge core_clk_i);
  endtask
endmodule // hps_src_model
